// File: src/ioc_pkg.sv
// constants, field layout and state record of the interrupt and option block
// assumes a single 100 MHz clock and a simple strobe register port
// Behaviour
// - pull-up disable bit forces all pull-ups off
// - edge select bit picks external pin edge
// - clock source bit picks pin or Fosc/4
// - source edge bit picks pin counting edge
// - shared prescaler serves watchdog or counter
// - rate field sets power-of-two division ratio
// - flags set whatever the enable bits say
// - global enable gates every interrupt source at irq_req; irq_out ignores it
// - peripheral enable gates all peripheral interrupts
// - counter rollover sets flag, enable gates it
// - counter value is not touched by reset
// - selected pin edge sets external flag
// - masked port change sets port change flag
// - flags stay set until software clears
// - peripheral enable register bit order fixed
package ioc_pkg;

  // ***************************************************************
  // register offsets
  // ***************************************************************
  localparam int unsigned AW = 4;
  localparam int unsigned DW = 8;
  localparam logic [AW-1:0] OFS_OPTION = 4'h0;
  localparam logic [AW-1:0] OFS_ICR    = 4'h1;
  localparam logic [AW-1:0] OFS_PERIPHERAL_IRQ_ENABLE_ONE   = 4'h2;
  localparam logic [AW-1:0] OFS_PULLUP = 4'h3;
  localparam logic [AW-1:0] OFS_CNMASK = 4'h4;
  localparam logic [AW-1:0] OFS_STATUS = 4'h5;
  localparam logic [AW-1:0] OFS_MASK   = 4'h6;
  localparam logic [AW-1:0] OFS_COUNT  = 4'h7;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int unsigned OPT_PULLUP_DIS = 7;
  localparam int unsigned OPT_EXT_EDGE   = 6;
  localparam int unsigned OPT_CLK_SRC    = 5;
  localparam int unsigned OPT_SRC_EDGE   = 4;
  localparam int unsigned OPT_PSA        = 3;
  localparam int unsigned OPT_PS_HI      = 2;
  localparam int unsigned ICR_GIE        = 7;
  localparam int unsigned ICR_PERIPH_IRQ_ENABLE       = 6;
  localparam int unsigned ICR_COV_IE     = 5;
  localparam int unsigned ICR_EXT_IE     = 4;
  localparam int unsigned ICR_PCH_IE     = 3;
  localparam int unsigned ICR_COV_F      = 2;
  localparam int unsigned ICR_EXT_F      = 1;
  localparam int unsigned ICR_PCH_F      = 0;
  localparam int unsigned EV_COV         = 0;
  localparam int unsigned EV_EXT         = 1;
  localparam int unsigned EV_PCH         = 2;
  localparam int unsigned EV_W           = 3;

  // ***************************************************************
  // reset values and timing
  // ***************************************************************
  localparam logic [DW-1:0] OPTION_RST = 8'hFF;
  localparam logic [DW-1:0] ICR_RST    = 8'h00;
  localparam logic [DW-1:0] PERIPHERAL_IRQ_ENABLE_ONE_RST   = 8'h00;
  localparam logic [DW-1:0] ZERO_RST   = 8'h00;
  localparam logic [DW-1:0] COUNT_TOP  = 8'hFF;
  localparam logic [1:0]    INSTR_LAST = 2'h3; // fosc/4 divider end
  localparam int unsigned   CLK_MHZ    = 100;

  typedef struct packed {
    logic          ext_s1;
    logic          ext_s2;
    logic          ext_prev;
    logic          tck_s1;
    logic          tck_s2;
    logic          tck_prev;
    logic [DW-1:0] pb_s1;
    logic [DW-1:0] pb_s2;
    logic [DW-1:0] pb_prev;
    logic [DW-1:0] option;
    logic [DW-1:0] icr;
    logic [DW-1:0] peripheral_irq_enable_one;
    logic [DW-1:0] pullmask;
    logic [DW-1:0] cnmask;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [1:0]    div;
    logic [DW-1:0] presc;
    logic [DW-1:0] rdata;
    logic          wdt_tick;
  } ioc_state_s;

endpackage

// File: src/ioc_top.sv
// interrupt gating, flags and option control of the core
// assumes pins are asynchronous, peripheral flags and watchdog tick are mclk-side
`timescale 1ns/1ns
module ioc_top (
  input  wire logic                  mclk,                  // system clock
  input  wire logic                  rst_b,                 // async reset, low
  input  wire logic [ioc_pkg::AW-1:0] addr,                 // register index
  input  wire logic [ioc_pkg::DW-1:0] wdata,                // write data
  input  wire logic                  wr,                    // write strobe
  input  wire logic                  rd,                    // read strobe
  output logic      [ioc_pkg::DW-1:0] rdata,                // read data, next cycle
  input  wire logic                  ext_interrupt_pin,     // external irq pin
  input  wire logic                  counter_ext_clock_pin, // counter clock pin
  input  wire logic [ioc_pkg::DW-1:0] portb_pins,           // port b levels
  input  wire logic [ioc_pkg::DW-1:0] periph_flags,         // peripheral flags
  input  wire logic                  watchdog_base_tick,    // watchdog source
  output logic      [ioc_pkg::DW-1:0] pullup_enable,        // weak pull-up on
  output logic                       watchdog_tick,         // watchdog step
  output logic      [ioc_pkg::DW-1:0] eight_bit_counter,    // counter value
  output logic                       irq_req,               // to the core
  output logic                       irq_out                // status line
);

  // ***************************************************************
  // state
  // ***************************************************************
  ioc_pkg::ioc_state_s q;
  ioc_pkg::ioc_state_s d;
  logic [ioc_pkg::DW-1:0] cnt_q;
  logic                  ext_edge;
  logic                  pin_edge;
  logic                  instr_tick;
  logic                  src_tick;
  logic                  presc_in;
  logic                  cnt_inc;
  logic                  cnt_wr;
  logic                  cnt_roll;
  logic                  port_chg;
  logic [2:0]            ps;
  logic [ioc_pkg::EV_W-1:0] events;

  // register index decode, shared by read and write paths
  function automatic logic hit(input logic [ioc_pkg::AW-1:0] a,
                               input logic [ioc_pkg::AW-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // true when the low k prescaler bits are all ones: a 1:2^k point
  function automatic logic div_hit(input logic [ioc_pkg::DW-1:0] p,
                                   input logic [3:0]            k);
    logic [ioc_pkg::DW-1:0] m;
    m = ioc_pkg::DW'((9'h001 << k) - 9'h001);
    div_hit = ((p & m) == m);
  endfunction

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    d = q;
    ps = q.option[ioc_pkg::OPT_PS_HI:0];

    // two-stage synchronisers; first stage feeds only the second
    d.ext_s1   = ext_interrupt_pin;
    d.ext_s2   = q.ext_s1;
    d.ext_prev = q.ext_s2;
    d.tck_s1   = counter_ext_clock_pin;
    d.tck_s2   = q.tck_s1;
    d.tck_prev = q.tck_s2;
    d.pb_s1    = portb_pins;
    d.pb_s2    = q.pb_s1;
    d.pb_prev  = q.pb_s2;

    // rising when set, falling when clear
    ext_edge = q.option[ioc_pkg::OPT_EXT_EDGE] ? (q.ext_s2 & ~q.ext_prev)
                                               : (~q.ext_s2 & q.ext_prev);
    // counts falling edges when set, rising when clear
    pin_edge = q.option[ioc_pkg::OPT_SRC_EDGE] ? (~q.tck_s2 & q.tck_prev)
                                               : (q.tck_s2 & ~q.tck_prev);

    // instruction cycle enable at a quarter of mclk
    instr_tick = (q.div == ioc_pkg::INSTR_LAST);
    d.div      = q.div + 2'h1;
    src_tick   = q.option[ioc_pkg::OPT_CLK_SRC] ? pin_edge : instr_tick;

    // one prescaler; the side without it runs undivided
    presc_in = q.option[ioc_pkg::OPT_PSA] ? watchdog_base_tick : src_tick;
    if (presc_in) begin
      d.presc = q.presc + 8'h01;
    end
    // counter divides 2..256, watchdog 1..128; undivided counter needs psa set
    cnt_inc = q.option[ioc_pkg::OPT_PSA] ? src_tick
            : (presc_in & div_hit(q.presc, {1'b0, ps} + 4'h1));
    d.wdt_tick = q.option[ioc_pkg::OPT_PSA] ? (presc_in & div_hit(q.presc, {1'b0, ps}))
               : watchdog_base_tick;

    // counter rollover, lost if software overwrites the counter that cycle
    cnt_wr   = wr & hit(addr, ioc_pkg::OFS_COUNT);
    cnt_roll = cnt_inc & ~cnt_wr & (cnt_q == ioc_pkg::COUNT_TOP);

    // any masked port pin that moved since the last cycle
    port_chg = |((q.pb_s2 ^ q.pb_prev) & q.cnmask);

    // software writes first, so hardware sets below win over a clear
    if (wr) begin
      if (hit(addr, ioc_pkg::OFS_OPTION)) d.option   = wdata;
      if (hit(addr, ioc_pkg::OFS_ICR))    d.icr      = wdata;
      if (hit(addr, ioc_pkg::OFS_PERIPHERAL_IRQ_ENABLE_ONE))   d.peripheral_irq_enable_one     = wdata;
      if (hit(addr, ioc_pkg::OFS_PULLUP)) d.pullmask = wdata;
      if (hit(addr, ioc_pkg::OFS_CNMASK)) d.cnmask   = wdata;
      if (hit(addr, ioc_pkg::OFS_MASK))   d.mask     = wdata[ioc_pkg::EV_W-1:0];
    end

    // flags set regardless of any enable bit
    if (cnt_roll) d.icr[ioc_pkg::ICR_COV_F] = 1'b1;
    if (ext_edge) d.icr[ioc_pkg::ICR_EXT_F] = 1'b1;
    if (port_chg) d.icr[ioc_pkg::ICR_PCH_F] = 1'b1;

    // sticky event status: read clears, a new event in that cycle stays
    events = '0;
    events[ioc_pkg::EV_COV] = cnt_roll;
    events[ioc_pkg::EV_EXT] = ext_edge;
    events[ioc_pkg::EV_PCH] = port_chg;
    if (rd & hit(addr, ioc_pkg::OFS_STATUS)) begin
      d.status = '0;
    end
    d.status = d.status | events;

    // read data live for exactly one cycle after the strobe
    d.rdata = '0;
    if (rd) begin
      case (addr)
        ioc_pkg::OFS_OPTION: d.rdata = q.option;
        ioc_pkg::OFS_ICR:    d.rdata = q.icr;
        ioc_pkg::OFS_PERIPHERAL_IRQ_ENABLE_ONE:   d.rdata = q.peripheral_irq_enable_one;
        ioc_pkg::OFS_PULLUP: d.rdata = q.pullmask;
        ioc_pkg::OFS_CNMASK: d.rdata = q.cnmask;
        ioc_pkg::OFS_STATUS: d.rdata = {{(ioc_pkg::DW-ioc_pkg::EV_W){1'b0}}, q.status};
        ioc_pkg::OFS_MASK:   d.rdata = {{(ioc_pkg::DW-ioc_pkg::EV_W){1'b0}}, q.mask};
        ioc_pkg::OFS_COUNT:  d.rdata = cnt_q;
        default:             d.rdata = '0;
      endcase
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q          <= '0;
      q.option   <= ioc_pkg::OPTION_RST;
      q.icr      <= ioc_pkg::ICR_RST;
      q.peripheral_irq_enable_one     <= ioc_pkg::PERIPHERAL_IRQ_ENABLE_ONE_RST;
      q.pullmask <= ioc_pkg::ZERO_RST;
      q.cnmask   <= ioc_pkg::ZERO_RST;
    end else begin
      q <= d;
    end
  end

  // counter keeps its value across reset, so it has no reset branch
  always_ff @(posedge mclk) begin
    if (cnt_wr) begin
      cnt_q <= wdata;
    end else if (cnt_inc) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  // disable bit overrides the per-pin mask
  assign pullup_enable = q.option[ioc_pkg::OPT_PULLUP_DIS] ? '0 : q.pullmask;
  assign watchdog_tick = q.wdt_tick;
  assign eight_bit_counter = cnt_q;
  assign rdata = q.rdata;

  // core request: global gate over core flags and the peripheral path
  assign irq_req = q.icr[ioc_pkg::ICR_GIE] & (
                   (q.icr[ioc_pkg::ICR_COV_IE] & q.icr[ioc_pkg::ICR_COV_F]) |
                   (q.icr[ioc_pkg::ICR_EXT_IE] & q.icr[ioc_pkg::ICR_EXT_F]) |
                   (q.icr[ioc_pkg::ICR_PCH_IE] & q.icr[ioc_pkg::ICR_PCH_F]) |
                   (q.icr[ioc_pkg::ICR_PERIPH_IRQ_ENABLE] & |(q.peripheral_irq_enable_one & periph_flags)));

  // status line ignores the global gate; it is a separate monitor path
  assign irq_out = |(q.status & q.mask);

endmodule

// File: verif/ioc_checker.sv
// port assertions for ioc_top
// assumes one clock domain and bind onto ioc_top
`timescale 1ns/1ns
module ioc_checker (
  input wire logic       mclk,               // clock
  input wire logic       rst_b,              // reset, low
  input wire logic [3:0] addr,               // index
  input wire logic [7:0] wdata,              // write data
  input wire logic       wr,                 // write strobe
  input wire logic       rd,                 // read strobe
  input wire logic [7:0] rdata,              // read data
  input wire logic [7:0] periph_flags,       // peripheral flags
  input wire logic       watchdog_base_tick, // tick in
  input wire logic [7:0] pullup_enable,      // pull-ups
  input wire logic       watchdog_tick,      // tick out
  input wire logic       irq_req,            // request
  input wire logic       irq_out             // status line
);
  logic [7:0] opt_q, pu_q, icr_q, pie_q, mk_q;
  // software view of control bits; hardware only touches icr flags
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      opt_q <= 8'hFF;
      {pu_q, icr_q, pie_q, mk_q} <= 32'h0;
    end else if (wr) begin
      if (addr == 4'h0) opt_q <= wdata;
      if (addr == 4'h1) icr_q <= wdata;
      if (addr == 4'h2) pie_q <= wdata;
      if (addr == 4'h3) pu_q <= wdata;
      if (addr == 4'h6) mk_q <= wdata;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_pullup_off: assert property (opt_q[7] |-> pullup_enable == 8'h00)
    else $error("pull-ups on while disabled");
  a_pullup_mask: assert property (!opt_q[7] |-> pullup_enable == pu_q)
    else $error("pull-ups differ from mask");
  a_global_gate: assert property (!icr_q[7] |-> !irq_req)
    else $error("request without global enable");
  a_periph_gate: assert property (icr_q[6:3] == 4'h0 |-> !irq_req)
    else $error("request with all sources off");
  a_periph_pass: assert property (icr_q[7] && icr_q[6] && |(pie_q & periph_flags) |-> irq_req)
    else $error("peripheral request lost");
  a_wdt_direct: assert property (watchdog_base_tick && !opt_q[3] |=> watchdog_tick)
    else $error("watchdog tick missing");
  a_wdt_source: assert property (!$past(watchdog_base_tick) |-> !watchdog_tick)
    else $error("watchdog tick without base");
  a_opt_read: assert property (rd && addr == 4'h0 |=> rdata == $past(opt_q))
    else $error("option read wrong");
  a_pie_read: assert property (rd && addr == 4'h2 |=> rdata == $past(pie_q))
    else $error("enable read wrong");
  a_mask_line: assert property (mk_q[2:0] == 3'h0 |-> !irq_out)
    else $error("line high while masked");
endmodule
bind ioc_top ioc_checker i_chk (.mclk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .periph_flags,
  .watchdog_base_tick, .pullup_enable, .watchdog_tick, .irq_req, .irq_out);

// File: verif/ioc_core_model.sv
// core that takes the combined request
// assumes irq_req is an mclk-domain level
`timescale 1ns/1ns
module ioc_core_model (
  input  wire logic       mclk,    // clock
  input  wire logic       rst_b,   // reset, low
  input  wire logic       irq_req, // request in
  output logic      [7:0] seen     // requests taken
);
  logic req_q;
  // a held level is one request, so count rises only
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      req_q <= 1'b0;
      seen  <= 8'h00;
    end else begin
      req_q <= irq_req;
      if (irq_req && !req_q) seen <= seen + 8'h01;
    end
  end
endmodule

// File: verif/ioc_top_bench.sv
// bench: register tasks and pin scenarios
// assumes checker and core model compiled first
`timescale 1ns/1ns
module ioc_top_bench;
  logic       mclk, rst_b, wr, rd, ext, tck, wdb, wdt, irq, irq_o;
  logic [3:0] addr;
  logic [7:0] wdata, pins, pfl, rdata, pu, cnt, seen;
  int         n_errors, checks_done, cyc, nt, i;
  ioc_top i_dut (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ext_interrupt_pin(ext), .counter_ext_clock_pin(tck), .portb_pins(pins),
    .periph_flags(pfl), .watchdog_base_tick(wdb), .pullup_enable(pu), .watchdog_tick(wdt),
    .eight_bit_counter(cnt), .irq_req(irq), .irq_out(irq_o));
  ioc_core_model i_core (.mclk(mclk), .rst_b(rst_b), .irq_req(irq), .seen(seen));
  // clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // hang guard and watchdog tick count
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (wdt === 1'b1) nt <= nt + 1;
    if (cyc == 5000) begin
      n_errors = n_errors + 1;
      finish_test();
    end
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 cmp(rdata, exp);
  endtask
  // pins change together; wait out sync and edge detect
  task automatic setp(input logic e, input logic t, input logic [7:0] p);
    @(posedge mclk);
    ext <= e;
    tck <= t;
    pins <= p;
    idle(6);
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    {wr, rd, ext, tck, wdb, rst_b} = 6'h00;
    {addr, wdata, pins, pfl} = 28'h0;
    {n_errors, checks_done, cyc, nt} = 0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    rreg(4'h0, 8'hFF);
    rreg(4'h1, 8'h00);
    rreg(4'h2, 8'h00);
    rreg(4'h9, 8'h00);
    cmp(pu, 8'h00);
    wreg(4'h3, 8'h5A);
    wreg(4'h0, 8'h7F);
    idle(1);
    cmp(pu, 8'h5A);
    // rising edge selected, enables off
    setp(1'b1, 1'b0, 8'h00);
    rreg(4'h1, 8'h02);
    rreg(4'h1, 8'h02);
    rreg(4'h5, 8'h02);
    rreg(4'h5, 8'h00);
    wreg(4'h1, 8'h00);
    wreg(4'h0, 8'h3F);
    setp(1'b0, 1'b0, 8'h00);
    rreg(4'h1, 8'h02);
    wreg(4'h1, 8'h00);
    setp(1'b1, 1'b0, 8'h00);
    rreg(4'h1, 8'h00);
    // pin-clocked counter, falling then rising edge
    wreg(4'h7, 8'h10);
    setp(1'b1, 1'b1, 8'h00);
    cmp(cnt, 8'h10);
    setp(1'b1, 1'b0, 8'h00);
    cmp(cnt, 8'h11);
    wreg(4'h0, 8'h2F);
    setp(1'b1, 1'b1, 8'h00);
    cmp(cnt, 8'h12);
    // mid-run reset: counter must survive, registers reload
    @(posedge mclk);
    rst_b <= 1'b0;
    idle(2);
    cmp(cnt, 8'h12);
    @(posedge mclk);
    rst_b <= 1'b1;
    rreg(4'h0, 8'hFF);
    cmp(cnt, 8'h12);
    // restore edge setup, drop the flag the resynced pin raised
    wreg(4'h0, 8'h2F);
    idle(6);
    wreg(4'h1, 8'h00);
    // port change through the notify mask
    wreg(4'h4, 8'h01);
    setp(1'b1, 1'b1, 8'h02);
    rreg(4'h1, 8'h00);
    wreg(4'h1, 8'h88);
    setp(1'b1, 1'b1, 8'h03);
    rreg(4'h1, 8'h89);
    cmp({7'h0, irq}, 8'h01);
    cmp(seen, 8'h01);
    wreg(4'h1, 8'h00);
    // peripheral path, one enable bit at a time
    for (i = 0; i < 8; i++) begin
      wreg(4'h2, 8'(1 << i));
      wreg(4'h1, 8'hC0);
      pfl <= ~8'(1 << i);
      idle(1);
      cmp({7'h0, irq}, 8'h00);
      @(posedge mclk);
      pfl <= 8'(1 << i);
      idle(1);
      cmp({7'h0, irq}, 8'h01);
      wreg(4'h1, 8'h40);
      idle(1);
      cmp({7'h0, irq}, 8'h00);
    end
    // undivided internal count rolls over
    wreg(4'h0, 8'h08);
    wreg(4'h7, 8'hFD);
    idle(20);
    rreg(4'h1, 8'h44);
    wreg(4'h1, 8'hA4);
    idle(1);
    cmp({7'h0, irq}, 8'h01);
    wreg(4'h1, 8'h44);
    wreg(4'h6, 8'h01);
    idle(1);
    cmp({7'h0, irq_o}, 8'h01);
    // ext and port change events left their status bits as well
    rreg(4'h5, 8'h07);
    idle(1);
    cmp({7'h0, irq_o}, 8'h00);
    // watchdog rate, then prescaler given to the counter
    for (i = 0; i < 4; i++) begin
      wreg(4'h0, (i == 3) ? 8'h00 : 8'(8'h08 | i));
      idle(2);
      nt = 0;
      repeat (8) begin
        @(posedge mclk);
        wdb <= 1'b1;
        @(posedge mclk);
        wdb <= 1'b0;
      end
      idle(3);
      cmp(8'(nt), (i == 3) ? 8'h08 : 8'(8 >> i));
    end
    finish_test();
  end
endmodule
